// *** rvs_pkg.sv ***
// constants for the receive view register bank and sync id filter
// assumes a 16-bit host register port with byte addresses
package rvs_pkg;
  // address and data widths of the host port
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  // filter and event registers
  localparam logic [8:0] OFS_SYNC_MASK = 9'h0EE;
  localparam logic [8:0] OFS_SYNC_VALUE = 9'h0F0;
  localparam logic [8:0] OFS_SYNC_REJECT = 9'h0F2;
  localparam logic [8:0] OFS_FILTER_CTRL = 9'h0F4;
  localparam logic [8:0] OFS_IRQ_STATUS = 9'h0F6;
  localparam logic [8:0] OFS_IRQ_MASK = 9'h0F8;
  // fifo view registers
  localparam logic [8:0] OFS_FIFO_FRAME_IDENT = 9'h100;
  localparam logic [8:0] OFS_FIFO_CYCLE_SIZE = 9'h102;
  localparam logic [8:0] OFS_FIFO_HDR_CSUM = 9'h104;
  localparam logic [8:0] OFS_FIFO_WORDS = 9'h106;
  localparam logic [8:0] OFS_FIFO_SLOT_STATUS = 9'h126;
  // receive view registers
  localparam logic [8:0] OFS_RX_CYCLE_SIZE = 9'h142;
  localparam logic [8:0] OFS_RX_HDR_CSUM = 9'h144;
  localparam logic [8:0] OFS_RX_WORDS = 9'h146;
  localparam logic [8:0] OFS_RX_SLOT_STATUS = 9'h166;
  // field widths
  localparam int IDENT_W = 11;
  localparam int FLAGS_W = 4;
  localparam int CYCLE_W = 6;
  localparam int SIZE_W = 7;
  localparam int CSUM_W = 11;
  localparam int SLOT_W = 9;
  localparam int WORD_COUNT = 16;
  // field positions
  localparam int CYCLE_LSB = 8;
  localparam int SIZE_LSB = 0;
  localparam int IDENT_LSB = 0;
  localparam int FLAGS_LSB = 11;
  localparam int FILTER_EN_BIT = 0;
  // interrupt event bits
  localparam int EV_RX_LOAD = 0;
  localparam int EV_FIFO_LOAD = 1;
  localparam int EV_SYNC_ACCEPT = 2;
  localparam int EV_SYNC_REJECT = 3;
  localparam int EV_WRITE_REFUSED = 4;
  localparam int EV_W = 5;
  // value of every register after reset
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : rvs_pkg

// *** rvs_regs.sv ***
// receive and fifo view registers plus sync frame identifier filter
// assumes controller-side inputs are on clk_i; host port never waits
// assumes the controller raises each load or check strobe for one cycle
// assumes the host never raises its read and write strobes together
// assumes config_state_i comes from logic on clk_i, so it is not synchronised
// register map, byte offsets of 16-bit words
//   0x0EE acceptance mask, bits 10:0, written only in configuration
//   0x0F0 acceptance value, bits 10:0, written only in configuration
//   0x0F2 rejection identifier, bits 10:0, written at any time
//   0x0F4 filter control, bit 0 enables the sync identifier filter
//   0x0F6 event status, sticky, write one to clear
//   0x0F8 event mask, same layout as the status word
//   0x100 fifo frame identifier with four frame indicators above it
//   0x102 fifo cycle count and payload size
//   0x104 fifo header checksum
//   0x106 to 0x124 fifo payload words
//   0x126 fifo slot status
//   0x142 receive cycle count and payload size
//   0x144 receive header checksum
//   0x146 to 0x164 receive payload words
//   0x166 receive slot status
//
// view word layouts
//   frame identifier: 15 reserved, 14 preamble, 13 null frame, 12 sync,
//     11 startup, 10:0 identifier
//   cycle and size: 15:14 reserved, 13:8 cycle count, 7 reserved, 6:0 size
//   header checksum: 15:11 reserved, 10:0 checksum
//   payload word n: 15:8 byte 2n+1, 7:0 byte 2n
//   slot status: 15:9 reserved, 8 bus line, 7:1 status flags, 0 conflict
//
// event status bits
//   0 receive view loaded, 1 fifo view loaded
//   2 sync frame accepted, 3 sync frame refused by the enabled filter
//   4 host write to a configuration-only register refused
//
// hazards and limits
//   every register clears to zero at reset, views and filter alike
//   a read in the same cycle as a load returns the old contents
//   a filter register written in the cycle of a check is not yet used
//   reserved bits read as zero and ignore writes
//   the host port never stalls; reads always answer one cycle later
//   refused writes leave the register as it was
//   the rejection identifier takes effect on the next check
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module rvs_regs
  import rvs_pkg::*;
#(
  parameter int NUM_WORDS = WORD_COUNT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // host register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // controller state
  input wire logic config_state_i,
  // receive view update from controller
  input wire logic rx_load_i,
  input wire logic [CYCLE_W-1:0] rx_cycle_i,
  input wire logic [SIZE_W-1:0] rx_size_i,
  input wire logic [CSUM_W-1:0] rx_csum_i,
  input wire logic [NUM_WORDS*DATA_W-1:0] rx_words_i,
  input wire logic [SLOT_W-1:0] rx_slot_i,
  // fifo view update from controller
  input wire logic fifo_load_i,
  input wire logic [FLAGS_W-1:0] fifo_flags_i,
  input wire logic [IDENT_W-1:0] fifo_ident_i,
  input wire logic [CYCLE_W-1:0] fifo_cycle_i,
  input wire logic [SIZE_W-1:0] fifo_size_i,
  input wire logic [CSUM_W-1:0] fifo_csum_i,
  input wire logic [NUM_WORDS*DATA_W-1:0] fifo_words_i,
  input wire logic [SLOT_W-1:0] fifo_slot_i,
  // sync frame check request and answer
  input wire logic sync_check_i,
  input wire logic [IDENT_W-1:0] sync_check_ident_i,
  output logic sync_check_done_o,
  output logic sync_check_accept_o,
  // interrupt
  output logic irq_o
);

  // the word windows are sized for exactly sixteen words
  if (NUM_WORDS != WORD_COUNT) begin : g_bad_words
    $error("rvs_regs: NUM_WORDS must equal WORD_COUNT");
  end

  // padding helper below assumes identifiers fill all but five bits
  if (IDENT_W + 5 != DATA_W || CSUM_W != IDENT_W) begin : g_bad_fields
    $error("rvs_regs: field widths do not fit the register word");
  end

  // whole state of the block
  typedef struct packed {
    // host port and sync check answers
    logic [DATA_W-1:0] rdata; // read answer
    logic irq; // interrupt level
    logic done; // check answered
    logic accept; // check result
    // filter registers
    logic [IDENT_W-1:0] acc_value; // acceptance value
    logic [IDENT_W-1:0] acc_mask; // acceptance mask
    logic [IDENT_W-1:0] reject_ident; // rejected identifier
    logic filter_en; // filter enable
    // event registers
    logic [EV_W-1:0] ev_status; // sticky events
    logic [EV_W-1:0] ev_mask; // event enables
    // fifo view contents
    logic [FLAGS_W-1:0] fifo_flags; // fifo frame indicators
    logic [IDENT_W-1:0] fifo_ident; // fifo frame identifier
    logic [CYCLE_W-1:0] fifo_cycle; // fifo cycle count
    logic [SIZE_W-1:0] fifo_size; // fifo payload size
    logic [CSUM_W-1:0] fifo_csum; // fifo header checksum
    logic [NUM_WORDS-1:0][DATA_W-1:0] fifo_words; // fifo payload
    logic [SLOT_W-1:0] fifo_slot; // fifo slot status
    // receive view contents
    logic [CYCLE_W-1:0] rx_cycle; // rx cycle count
    logic [SIZE_W-1:0] rx_size; // rx payload size
    logic [CSUM_W-1:0] rx_csum; // rx header checksum
    logic [NUM_WORDS-1:0][DATA_W-1:0] rx_words; // rx payload
    logic [SLOT_W-1:0] rx_slot; // rx slot status
  } rvs_state_s;

  rvs_state_s st_reg;
  rvs_state_s st_next;

  // hit test for a word window: {hit, index}
  // odd offsets and addresses below the base miss
  function automatic logic [4:0] word_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] diff;
    diff = addr - base;
    if (addr >= base && diff < ADDR_W'(2 * NUM_WORDS) && !diff[0]) begin
      word_hit = {1'b1, diff[4:1]};
    end else begin
      word_hit = 5'h00;
    end
  endfunction : word_hit

  // masked compare plus rejection identifier
  // both conditions are needed for acceptance
  function automatic logic ident_passes(
    input logic [IDENT_W-1:0] ident,
    input logic [IDENT_W-1:0] value,
    input logic [IDENT_W-1:0] mask,
    input logic [IDENT_W-1:0] reject
  );
    logic masked_ok;
    masked_ok = ~|((ident ^ value) & mask);
    ident_passes = masked_ok && (ident != reject);
  endfunction : ident_passes

  // pad a narrow field into a register word
  // used for identifiers and checksums, both eleven bits wide
  function automatic logic [DATA_W-1:0] fit(input logic [IDENT_W-1:0] v);
    fit = {5'h00, v};
  endfunction : fit

  // cycle count above payload size, reserved bits zero
  function automatic logic [DATA_W-1:0] cycle_size_word(
    input logic [CYCLE_W-1:0] cycle,
    input logic [SIZE_W-1:0] size
  );
    cycle_size_word = REG_RESET;
    cycle_size_word[CYCLE_LSB +: CYCLE_W] = cycle;
    cycle_size_word[SIZE_LSB +: SIZE_W] = size;
  endfunction : cycle_size_word

  // slot status in the low bits, reserved bits zero
  function automatic logic [DATA_W-1:0] slot_word(input logic [SLOT_W-1:0] slot);
    slot_word = REG_RESET;
    slot_word[SLOT_W-1:0] = slot;
  endfunction : slot_word

  // combinational next state
  always_comb begin
    logic [4:0] fifo_hit;
    logic [4:0] rx_hit;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] w1c;
    logic pass;
    fifo_hit = word_hit(reg_addr_i, OFS_FIFO_WORDS);
    rx_hit = word_hit(reg_addr_i, OFS_RX_WORDS);
    events = '0;
    w1c = '0;
    // filter verdict from registers as they stand this cycle
    pass = ident_passes(sync_check_ident_i, st_reg.acc_value,
                        st_reg.acc_mask, st_reg.reject_ident);
    // hold everything, then drop the one-cycle answers
    st_next = st_reg;
    st_next.rdata = REG_RESET;
    st_next.done = 1'b0;
    st_next.accept = 1'b0;

    // host writes; view registers simply ignore them
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        // mask, configuration only like the acceptance value
        OFS_SYNC_MASK: begin
          if (config_state_i) begin
            st_next.acc_mask = reg_wdata_i[IDENT_W-1:0];
          end else begin
            // refused: flagged so software can see it
            events[EV_WRITE_REFUSED] = 1'b1;
          end
        end
        // acceptance value, configuration only
        OFS_SYNC_VALUE: begin
          if (config_state_i) begin
            st_next.acc_value = reg_wdata_i[IDENT_W-1:0];
          end else begin
            // refused: flagged so software can see it
            events[EV_WRITE_REFUSED] = 1'b1;
          end
        end
        // rejection identifier, any state
        OFS_SYNC_REJECT: begin
          st_next.reject_ident = reg_wdata_i[IDENT_W-1:0];
        end
        // filter control
        OFS_FILTER_CTRL: begin
          st_next.filter_en = reg_wdata_i[FILTER_EN_BIT];
        end
        // event status, write one to clear
        OFS_IRQ_STATUS: begin
          w1c = reg_wdata_i[EV_W-1:0];
        end
        // event mask
        OFS_IRQ_MASK: begin
          st_next.ev_mask = reg_wdata_i[EV_W-1:0];
        end
        default: begin
          // read-only views and unmapped addresses drop the write
          st_next.filter_en = st_reg.filter_en;
        end
      endcase
    end

    // host reads, answered in the next cycle without side effects
    if (reg_rd_i) begin
      // payload word windows first, one word per even offset
      if (fifo_hit[4]) begin
        st_next.rdata = st_reg.fifo_words[fifo_hit[3:0]];
      end else if (rx_hit[4]) begin
        st_next.rdata = st_reg.rx_words[rx_hit[3:0]];
      end else begin
        // single registers; reserved bits stay zero from the default above
        unique case (reg_addr_i)
          // filter registers
          OFS_SYNC_MASK: st_next.rdata = fit(st_reg.acc_mask);
          OFS_SYNC_VALUE: st_next.rdata = fit(st_reg.acc_value);
          OFS_SYNC_REJECT: st_next.rdata = fit(st_reg.reject_ident);
          OFS_FILTER_CTRL: begin
            st_next.rdata[FILTER_EN_BIT] = st_reg.filter_en;
          end
          // event status and mask
          OFS_IRQ_STATUS: st_next.rdata[EV_W-1:0] = st_reg.ev_status;
          OFS_IRQ_MASK: st_next.rdata[EV_W-1:0] = st_reg.ev_mask;
          // fifo view: indicators above the identifier, bit 15 reserved
          OFS_FIFO_FRAME_IDENT: begin
            st_next.rdata[FLAGS_LSB +: FLAGS_W] = st_reg.fifo_flags;
            st_next.rdata[IDENT_LSB +: IDENT_W] = st_reg.fifo_ident;
          end
          // fifo view: cycle count, size and checksum
          OFS_FIFO_CYCLE_SIZE: begin
            st_next.rdata = cycle_size_word(st_reg.fifo_cycle, st_reg.fifo_size);
          end
          OFS_FIFO_HDR_CSUM: begin
            st_next.rdata = fit(st_reg.fifo_csum);
          end
          // fifo view: slot status
          OFS_FIFO_SLOT_STATUS: begin
            st_next.rdata = slot_word(st_reg.fifo_slot);
          end
          // receive view: cycle count, size and checksum
          OFS_RX_CYCLE_SIZE: begin
            st_next.rdata = cycle_size_word(st_reg.rx_cycle, st_reg.rx_size);
          end
          OFS_RX_HDR_CSUM: begin
            st_next.rdata = fit(st_reg.rx_csum);
          end
          // receive view: slot status
          OFS_RX_SLOT_STATUS: begin
            st_next.rdata = slot_word(st_reg.rx_slot);
          end
          default: begin
            // unmapped: reads as zero
            st_next.rdata = REG_RESET;
          end
        endcase
      end
    end

    // controller updates the receive view as a whole
    if (rx_load_i) begin
      st_next.rx_cycle = rx_cycle_i;
      st_next.rx_size = rx_size_i;
      st_next.rx_csum = rx_csum_i;
      st_next.rx_words = rx_words_i;
      st_next.rx_slot = rx_slot_i;
      // status bit tells software a new frame is in view
      events[EV_RX_LOAD] = 1'b1;
    end

    // controller updates the fifo view as a whole
    if (fifo_load_i) begin
      st_next.fifo_flags = fifo_flags_i;
      st_next.fifo_ident = fifo_ident_i;
      st_next.fifo_cycle = fifo_cycle_i;
      st_next.fifo_size = fifo_size_i;
      st_next.fifo_csum = fifo_csum_i;
      st_next.fifo_words = fifo_words_i;
      st_next.fifo_slot = fifo_slot_i;
      // status bit tells software a new fifo entry is in view
      events[EV_FIFO_LOAD] = 1'b1;
    end

    // sync frame check: filter off lets every valid sync frame through
    if (sync_check_i) begin
      // refusals are only counted while the filter is enabled
      st_next.done = 1'b1;
      st_next.accept = !st_reg.filter_en || pass;
      events[EV_SYNC_ACCEPT] = !st_reg.filter_en || pass;
      events[EV_SYNC_REJECT] = st_reg.filter_en && !pass;
    end

    // sticky events: a new event beats a clear in the same cycle
    st_next.ev_status = (st_reg.ev_status & ~w1c) | events;
    // interrupt follows the next status so it rises with the event
    st_next.irq = |(st_next.ev_status & st_next.ev_mask);
  end

  // state register, synchronous active-low reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      // every field clears, so views read zero until loaded
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flip-flops
  // no logic between the state and the pins
  assign reg_rdata_o = st_reg.rdata;
  assign sync_check_done_o = st_reg.done;
  assign sync_check_accept_o = st_reg.accept;
  assign irq_o = st_reg.irq;

endmodule : rvs_regs

// *** rvs_regs_props.sv ***
// assertions on the rvs_regs host port and sync check ports
// assumes a bind onto rvs_regs, one clock, synchronous reset
`timescale 1ns/10ps
module rvs_regs_chk
  import rvs_pkg::*;
#(
  parameter int NUM_WORDS = WORD_COUNT
) (
  // watched ports
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic sync_check_i,
  input wire logic sync_check_done_o,
  input wire logic sync_check_accept_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // reads of each register kind
  wire logic [8:0] a = reg_addr_i;
  wire logic rd_cs = reg_rd_i && (a == OFS_RX_CYCLE_SIZE || a == OFS_FIFO_CYCLE_SIZE);
  wire logic rd_hc = reg_rd_i && (a == OFS_RX_HDR_CSUM || a == OFS_FIFO_HDR_CSUM);
  wire logic rd_ss = reg_rd_i && (a == OFS_RX_SLOT_STATUS || a == OFS_FIFO_SLOT_STATUS);
  AST_QUIET: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside slot");
  AST_ODD: assert property (reg_rd_i && a[0] |=> reg_rdata_o == '0)
    else $error("odd read not zero");
  AST_CS: assert property (rd_cs |=> reg_rdata_o[15:14] == 2'h0 && !reg_rdata_o[7])
    else $error("cycle size reserved bits set");
  AST_CSUM: assert property (rd_hc |=> reg_rdata_o[15:11] == 5'h00)
    else $error("checksum reserved bits set");
  AST_SLOT: assert property (rd_ss |=> reg_rdata_o[15:9] == 7'h00)
    else $error("slot status reserved bits set");
  AST_IDENT: assert property (reg_rd_i && a == OFS_FIFO_FRAME_IDENT |=> !reg_rdata_o[15])
    else $error("ident reserved bit set");
  AST_DONE: assert property (sync_check_i |=> sync_check_done_o)
    else $error("sync check not answered");
  AST_CAUSE: assert property (sync_check_done_o |-> $past(sync_check_i))
    else $error("done without request");
  AST_ACC: assert property (sync_check_accept_o |-> sync_check_done_o)
    else $error("accept without done");
  // main scenarios seen
  cover property (sync_check_accept_o);
  cover property (sync_check_done_o && !sync_check_accept_o);
  cover property (irq_o);
endmodule : rvs_regs_chk
bind rvs_regs rvs_regs_chk #(.NUM_WORDS(NUM_WORDS)) u_rvs_regs_chk (.*);

// *** rx_view_regs_sync_id_filter_tb.sv ***
// self-checking bench for the view bank and sync id filter
// assumes rvs_regs on a 25 MHz clock with synchronous low reset
`timescale 1ns/10ps
module rx_view_regs_sync_id_filter_tb;
  import rvs_pkg::*;
  // design inputs and outputs
  logic clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, config_state_i = 1;
  logic rx_load_i = 0, fifo_load_i = 0, sync_check_i = 0, en;
  logic sync_check_done_o, sync_check_accept_o, irq_o;
  logic [ADDR_W-1:0] reg_addr_i = '0, b;
  logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o, e;
  logic [CYCLE_W-1:0] rx_cycle_i = '0, fifo_cycle_i = '0;
  logic [SIZE_W-1:0] rx_size_i = '0, fifo_size_i = '0;
  logic [CSUM_W-1:0] rx_csum_i = '0, fifo_csum_i = '0;
  logic [IDENT_W-1:0] fifo_ident_i = '0, sync_check_ident_i = '0, id, val, msk, rej;
  logic [FLAGS_W-1:0] fifo_flags_i = '0;
  logic [SLOT_W-1:0] rx_slot_i = '0, fifo_slot_i = '0;
  logic [WORD_COUNT*DATA_W-1:0] rx_words_i = '0, fifo_words_i = '0;
  int fail_count = 0, checks = 0, cyc = 0, seed = 32'h79BBED00;
  rvs_regs u_rvs_regs (.*);
  // 40 ns clock
  initial forever #20 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report;
    end
  end
  // compare and count
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
    checks++;
    if (s !== x) begin
      $display("mismatch %s exp %h got %h", n, x, s);
      fail_count++;
    end
  endtask : chk
  // one-cycle host write
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // one-cycle host read, data in the next cycle
  task automatic rd(input logic [8:0] a, input logic [15:0] x);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), x, reg_rdata_o);
  endtask : rd
  // sync frame check, answer one cycle later
  task automatic sc(input logic x);
    @(posedge clk_i);
    sync_check_i <= 1'b1;
    sync_check_ident_i <= id;
    @(posedge clk_i);
    sync_check_i <= 1'b0;
    #1 chk("done", 16'h1, {15'h0, sync_check_done_o});
    chk("accept", {15'h0, x}, {15'h0, sync_check_accept_o});
  endtask : sc
  // expected filter verdict
  function automatic logic acc();
    return !en || (((id ^ val) & msk) == '0 && id != rej);
  endfunction : acc
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(OFS_SYNC_VALUE, REG_RESET);
    $display("test reset done");
    wr(OFS_IRQ_MASK, 16'h0001);
    @(posedge clk_i);
    {rx_cycle_i, rx_size_i, rx_csum_i, rx_slot_i} <= 33'({$random(seed), $random(seed)});
    {fifo_flags_i, fifo_ident_i, fifo_cycle_i, fifo_size_i, fifo_csum_i, fifo_slot_i} <=
      48'({$random(seed), $random(seed)});
    for (int i = 0; i < 8; i++) begin
      rx_words_i[32*i+:32] <= $random(seed);
      fifo_words_i[32*i+:32] <= $random(seed);
    end
    rx_load_i <= 1'b1;
    fifo_load_i <= 1'b1;
    @(posedge clk_i);
    rx_load_i <= 1'b0;
    fifo_load_i <= 1'b0;
    // both views, fifo first
    for (int v = 0; v < 2; v++) begin
      b = v ? OFS_RX_CYCLE_SIZE - 9'h002 : OFS_FIFO_FRAME_IDENT;
      if (v == 0) rd(b, {1'b0, fifo_flags_i, fifo_ident_i});
      e = v ? {2'h0, rx_cycle_i, 1'b0, rx_size_i} : {2'h0, fifo_cycle_i, 1'b0, fifo_size_i};
      rd(b + 9'h002, e);
      wr(b + 9'h002, ~e);
      rd(b + 9'h002, e);
      rd(b + 9'h004, v ? {5'h0, rx_csum_i} : {5'h0, fifo_csum_i});
      for (int n = 0; n < WORD_COUNT; n++) begin
        e = v ? rx_words_i[16*n+:16] : fifo_words_i[16*n+:16];
        rd(b + 9'(6 + 2 * n), e);
      end
      rd(b + 9'h026, v ? {7'h0, rx_slot_i} : {7'h0, fifo_slot_i});
    end
    // interrupt raised, masked, cleared
    chk("irq", 16'h1, {15'h0, irq_o});
    rd(OFS_IRQ_STATUS, 16'h0003);
    wr(OFS_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", 16'h0, {15'h0, irq_o});
    $display("test views done");
    // filter with random and corner settings
    for (int i = 0; i < 60; i++) begin
      {en, id, val, msk, rej} = 45'({$random(seed), $random(seed)});
      if (i % 2 == 1) val = id ^ ~msk;
      if (i % 5 == 0) rej = id;
      if (i == 0) {en, msk, rej} = {1'b1, 11'h000, id};
      if (i == 1) {en, msk, rej} = {1'b1, 11'h000, ~id};
      wr(OFS_FILTER_CTRL, {15'h0, en});
      wr(OFS_SYNC_MASK, {5'h1F, msk});
      wr(OFS_SYNC_VALUE, {5'h1F, val});
      wr(OFS_SYNC_REJECT, {5'h0, rej});
      sc(acc());
    end
    rd(OFS_SYNC_VALUE, {5'h0, val});
    rd(OFS_FILTER_CTRL, {15'h0, en});
    rd(OFS_SYNC_MASK, {5'h0, msk});
    $display("test filter done");
    // writes outside configuration
    wr(OFS_IRQ_STATUS, 16'h001F);
    config_state_i <= 1'b0;
    wr(OFS_SYNC_VALUE, {5'h0, ~val});
    rd(OFS_SYNC_VALUE, {5'h0, val});
    wr(OFS_SYNC_MASK, {5'h0, ~msk});
    rd(OFS_SYNC_MASK, {5'h0, msk});
    rd(OFS_IRQ_STATUS, 16'h0010);
    wr(OFS_SYNC_REJECT, {5'h0, ~rej});
    rd(OFS_SYNC_REJECT, {5'h0, ~rej});
    rd(9'h101, 16'h0000);
    rd(9'h1F0, 16'h0000);
    $display("test refusal done");
    final_report;
  end
endmodule : rx_view_regs_sync_id_filter_tb
